/* File: rtl/sfcp_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sfcp_top
	import sfcp_pkg::*;
#(
	parameter int AW = 24
) (
	// System.
	input  wire logic          clock_in,
	input  wire logic          rst_b_in,
	// Serial link.
	input  wire logic          sck_in,
	input  wire logic          cs_b_in,
	input  wire logic          si_in,
	input  wire logic          wp_b_in,
	// Configuration.
	input  wire logic [1:0]    density_in,
	input  wire logic          engine_busy_in,
	// Status.
	output logic               write_latch_bit_out,
	output logic               protect_lock_bit_out,
	output logic [2:0]         protect_level_out,
	output logic               busy_out_enable_out,
	output logic               hold_function_out,
	output logic               aai_mode_out,
	// Commands to the array engine.
	output logic               cmd_valid_out,
	output sfcp_event_t        cmd_kind_out,
	output logic [AW-1:0]      cmd_addr_out,
	output logic [7:0]         cmd_data_out,
	output logic               read_active_out,
	output logic               refused_out
);
	// ------------------------------------------------------------
	// Link domain: shifter on the serial clock.
	// ------------------------------------------------------------
	sfcp_state_t    st;
	logic [2:0]     bit_cnt;
	logic [6:0]     shreg;
	logic [7:0]     opcode;
	logic [1:0]     addr_cnt;
	logic [AW-1:0]  addr_l;
	logic [7:0]     data_l;
	logic [1:0]     data_cnt;
	logic           frame_ok;
	logic           read_l;
	logic [7:0]     next_byte;

	assign next_byte = {shreg, si_in};

	function automatic logic takes_addr(input logic [7:0] op);
		return op == OP_READ || op == OP_FAST_READ || op == OP_SECT_ERASE ||
		       op == OP_BLK_ERASE || op == OP_BYTE_PROG || op == OP_AAI_PROG ||
		       op == OP_ID_READ_A || op == OP_ID_READ_B;
	endfunction : takes_addr

	function automatic logic is_stream(input logic [7:0] op);
		return op == OP_READ || op == OP_FAST_READ || op == OP_STAT_READ ||
		       op == OP_ID_READ_A || op == OP_ID_READ_B || op == OP_STD_ID;
	endfunction : is_stream

	// Chip select high acts as the async reset of the link logic, so every
	// frame starts afresh on the falling edge of select.
	always_ff @(posedge sck_in or posedge cs_b_in) begin
		if (cs_b_in) begin
			st       <= SFCP_OPC;
			bit_cnt  <= 3'h0;
			shreg    <= 7'h00;
			addr_cnt <= 2'h0;
		end else begin
			shreg   <= next_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				case (st)
					SFCP_OPC: begin
						if (takes_addr(next_byte)) st <= SFCP_ADDR;
						else if (is_stream(next_byte)) st <= SFCP_STREAM;
						else st <= SFCP_DATA;
					end
					SFCP_ADDR: begin
						addr_cnt <= addr_cnt + 2'h1;
						if (addr_cnt == 2'(ADDR_BYTES - 1)) begin
							if (opcode == OP_FAST_READ) st <= SFCP_DUMMY;
							else if (is_stream(opcode)) st <= SFCP_STREAM;
							else st <= SFCP_DATA;
						end
					end
					SFCP_DUMMY: st <= SFCP_STREAM;
					SFCP_DATA:   st <= SFCP_DATA;
					SFCP_STREAM: st <= SFCP_STREAM;
					default:     st <= SFCP_IGNORE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Captured fields.
	// ------------------------------------------------------------
	// These are held across select high so the system side can read them
	// after the frame-end toggle. By then the link clock has stopped, so
	// they cannot move while the system side reads them.
	always_ff @(posedge sck_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			opcode   <= 8'h00;
			addr_l   <= '0;
			data_l   <= 8'h00;
			data_cnt <= 2'h0;
			frame_ok <= 1'b0;
			read_l   <= 1'b0;
		end else if (!cs_b_in && bit_cnt == 3'h7) begin
			frame_ok <= 1'b0;
			case (st)
				SFCP_OPC: begin
					opcode   <= next_byte;
					data_cnt <= 2'h0;
					read_l   <= 1'b0;
					frame_ok <= !takes_addr(next_byte) && !is_stream(next_byte);
				end
				SFCP_ADDR: begin
					addr_l   <= {addr_l[AW-9:0], next_byte};
					frame_ok <= addr_cnt == 2'(ADDR_BYTES - 1);
					read_l   <= addr_cnt == 2'(ADDR_BYTES - 1) && is_stream(opcode);
				end
				SFCP_DATA: begin
					data_l   <= next_byte;
					frame_ok <= 1'b1;
					if (data_cnt != 2'h3) data_cnt <= data_cnt + 2'h1;
				end
				SFCP_STREAM: read_l <= 1'b1;
				default: frame_ok <= 1'b0;
			endcase
		end else if (!cs_b_in && bit_cnt == 3'h0 && st == SFCP_OPC) begin
			frame_ok <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Frame end.
	// ------------------------------------------------------------
	// On the select rise, record whether the last byte was whole.
	// A select pulse with no clock at all leaves the state at the opcode
	// stage. It must not apply the previous frame's fields a second time.
	logic frame_tog;
	logic frame_done_ok;
	always_ff @(posedge cs_b_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			frame_tog     <= 1'b0;
			frame_done_ok <= 1'b0;
		end else begin
			frame_tog     <= !frame_tog;
			frame_done_ok <= frame_ok && bit_cnt == 3'h0 && st != SFCP_OPC;
		end
	end

	// ------------------------------------------------------------
	// System domain: crossings and the status bits.
	// ------------------------------------------------------------
	logic [1:0] sync_ctl;
	logic       wp_s;
	logic       tog_d;
	logic       frame_pulse;
	sfcp_sync #(.WIDTH(2)) u_sync_ctl (
		.clock_in (clock_in),
		.rst_b_in (rst_b_in),
		.async_in ({frame_tog, read_l & ~cs_b_in}),
		.sync_out (sync_ctl)
	);
	sfcp_sync #(.WIDTH(1)) u_sync_wp (
		.clock_in (clock_in),
		.rst_b_in (rst_b_in),
		.async_in (wp_b_in),
		.sync_out (wp_s)
	);

	// ------------------------------------------------------------
	// Frame pulse.
	// ------------------------------------------------------------
	// Frame fields are stable once the toggle has been synchronised.
	// The fields cross without synchronisers of their own. This is safe
	// only because the host leaves at least twenty system clocks between frames, and
	// a new opcode lands no sooner than eight link clocks into the next one.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tog_d       <= 1'b0;
			frame_pulse <= 1'b0;
		end else begin
			tog_d       <= sync_ctl[1];
			frame_pulse <= (sync_ctl[1] != tog_d) && frame_done_ok;
		end
	end

	// ------------------------------------------------------------
	// Protection map.
	// ------------------------------------------------------------
	// The check is registered and so costs a cycle. The address never
	// needs that cycle, because it settles long before the frame pulse.
	logic prot_hit;
	sfcp_range #(.AW(AW)) u_range (
		.clock_in      (clock_in),
		.rst_b_in      (rst_b_in),
		.density_in    (density_in),
		.level_in      (protect_level_out),
		.addr_in       (addr_l),
		.protected_out (prot_hit)
	);

	logic        swen;
	logic        status_ok;
	logic        prot_ok;
	sfcp_event_t next_kind;

	assign status_ok = wp_s || !protect_lock_bit_out;

	// ------------------------------------------------------------
	// Command decode.
	// ------------------------------------------------------------
	// A write command that arrives without its data byte decodes as
	// nothing. A truncated program therefore neither runs nor clears the
	// latch.

	always_comb begin
		next_kind = SFCP_EV_NONE;
		case (opcode)
			OP_WRITE_EN:   next_kind = SFCP_EV_WEN;
			OP_WRITE_DIS:  next_kind = SFCP_EV_WDIS;
			OP_STAT_WEN:   next_kind = SFCP_EV_SWEN;
			OP_STAT_WRITE: next_kind = data_cnt != 2'h0 ? SFCP_EV_SWRITE : SFCP_EV_NONE;
			OP_BYTE_PROG:  next_kind = data_cnt != 2'h0 ? SFCP_EV_BPROG : SFCP_EV_NONE;
			OP_AAI_PROG:   next_kind = data_cnt[1] ? SFCP_EV_AAI : SFCP_EV_NONE;
			OP_SECT_ERASE: next_kind = SFCP_EV_SERASE;
			OP_BLK_ERASE:  next_kind = SFCP_EV_BERASE;
			OP_CHIP_ERA_A: next_kind = SFCP_EV_CERASE;
			OP_CHIP_ERA_B: next_kind = SFCP_EV_CERASE;
			OP_BUSY_EN:    next_kind = SFCP_EV_BUSYEN;
			OP_BUSY_DIS:   next_kind = SFCP_EV_BUSYDIS;
			OP_HOLD_EN:    next_kind = SFCP_EV_HOLDEN;
			default:       next_kind = SFCP_EV_NONE;
		endcase
	end

	// ------------------------------------------------------------
	// Program and erase acceptance.
	// ------------------------------------------------------------
	// A busy engine refuses rather than queues, so the host must poll and
	// then retry.
	always_comb begin
		prot_ok = 1'b0;
		case (next_kind)
			SFCP_EV_BPROG, SFCP_EV_AAI, SFCP_EV_SERASE, SFCP_EV_BERASE:
				prot_ok = write_latch_bit_out && !prot_hit && !engine_busy_in;
			SFCP_EV_CERASE:
				prot_ok = write_latch_bit_out && protect_level_out == 3'h0 &&
				          !engine_busy_in;
			default: prot_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cmd_valid_out <= 1'b0;
			cmd_kind_out  <= SFCP_EV_NONE;
			cmd_addr_out  <= '0;
			cmd_data_out  <= 8'h00;
			refused_out   <= 1'b0;
		end else begin
			cmd_valid_out <= frame_pulse && prot_ok;
			refused_out   <= frame_pulse && !prot_ok && next_kind inside
			                 {SFCP_EV_BPROG, SFCP_EV_AAI, SFCP_EV_SERASE,
			                  SFCP_EV_BERASE, SFCP_EV_CERASE};
			if (frame_pulse) begin
				cmd_kind_out <= next_kind;
				cmd_addr_out <= addr_l;
				cmd_data_out <= data_l;
			end
		end
	end

	// ------------------------------------------------------------
	// Write latch and status-write enable.
	// ------------------------------------------------------------
	// A refused write still clears the latch. The host must therefore
	// enable writes again before it retries.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			write_latch_bit_out <= 1'b0;
			swen                <= 1'b0;
		end else if (frame_pulse) begin
			case (next_kind)
				SFCP_EV_WEN:  write_latch_bit_out <= 1'b1;
				SFCP_EV_SWEN: swen <= 1'b1;
				SFCP_EV_WDIS, SFCP_EV_SWRITE, SFCP_EV_BPROG, SFCP_EV_AAI,
				SFCP_EV_SERASE, SFCP_EV_BERASE, SFCP_EV_CERASE: begin
					write_latch_bit_out <= 1'b0;
					swen                <= 1'b0;
				end
				default: swen <= 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Protection bits.
	// ------------------------------------------------------------
	// A status write that is not allowed leaves lock and level untouched.
	// The pin is read through its synchroniser, so a change on the pin
	// takes two system clocks to count.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			protect_lock_bit_out <= LOCK_RESET;
			protect_level_out    <= LEVEL_RESET;
		end else if (frame_pulse && next_kind == SFCP_EV_SWRITE &&
		             (write_latch_bit_out || swen) && status_ok) begin
			protect_lock_bit_out <= data_l[STAT_LOCK_POS];
			protect_level_out    <= density_in == DENS_4M ?
			                        data_l[STAT_LVL_POS+2:STAT_LVL_POS] :
			                        {1'b0, data_l[STAT_LVL_POS+1:STAT_LVL_POS]};
		end
	end

	// ------------------------------------------------------------
	// Modes.
	// ------------------------------------------------------------
	// Hold stays on until reset, because no command turns it off again.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_out_enable_out <= 1'b0;
			hold_function_out   <= 1'b0;
			aai_mode_out        <= 1'b0;
			read_active_out     <= 1'b0;
		end else begin
			read_active_out <= sync_ctl[0];
			if (frame_pulse) begin
				if (next_kind == SFCP_EV_BUSYEN)  busy_out_enable_out <= 1'b1;
				if (next_kind == SFCP_EV_BUSYDIS) busy_out_enable_out <= 1'b0;
				if (next_kind == SFCP_EV_HOLDEN)  hold_function_out   <= 1'b1;
				aai_mode_out <= next_kind == SFCP_EV_AAI && prot_ok;
			end
		end
	end
endmodule : sfcp_top
`default_nettype wire

/* File: rtl/sfcp_pkg.sv */
`default_nettype none
package sfcp_pkg;
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_FAST_READ  = 8'h0b;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_BLK_ERASE  = 8'h52;
	localparam logic [7:0] OP_CHIP_ERA_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERA_B = 8'hc7;
	localparam logic [7:0] OP_BYTE_PROG  = 8'h02;
	localparam logic [7:0] OP_AAI_PROG   = 8'had;
	localparam logic [7:0] OP_STAT_READ  = 8'h05;
	localparam logic [7:0] OP_STAT_WEN   = 8'h50;
	localparam logic [7:0] OP_STAT_WRITE = 8'h01;
	localparam logic [7:0] OP_WRITE_EN   = 8'h06;
	localparam logic [7:0] OP_WRITE_DIS  = 8'h04;
	localparam logic [7:0] OP_ID_READ_A  = 8'h90;
	localparam logic [7:0] OP_ID_READ_B  = 8'hab;
	localparam logic [7:0] OP_STD_ID     = 8'h9f;
	localparam logic [7:0] OP_BUSY_EN    = 8'h70;
	localparam logic [7:0] OP_BUSY_DIS   = 8'h80;
	localparam logic [7:0] OP_HOLD_EN    = 8'haa;
	localparam int         ADDR_BYTES    = 3;
	localparam logic [2:0] LEVEL_RESET   = 3'h7;
	localparam logic       LOCK_RESET    = 1'h0;
	localparam int         STAT_LOCK_POS = 7;
	localparam int         STAT_LVL_POS  = 2;
	// Density codes: 0=512Kbit 1=1Mbit 2=2Mbit 3=4Mbit.
	localparam logic [1:0] DENS_512K     = 2'h0;
	localparam logic [1:0] DENS_1M       = 2'h1;
	localparam logic [1:0] DENS_2M       = 2'h2;
	localparam logic [1:0] DENS_4M       = 2'h3;
	typedef enum logic [2:0] {
		SFCP_OPC, SFCP_ADDR, SFCP_DUMMY, SFCP_DATA, SFCP_STREAM, SFCP_IGNORE
	} sfcp_state_t;
	typedef enum logic [3:0] {
		SFCP_EV_NONE, SFCP_EV_WEN, SFCP_EV_WDIS, SFCP_EV_SWEN, SFCP_EV_SWRITE,
		SFCP_EV_BPROG, SFCP_EV_AAI, SFCP_EV_SERASE, SFCP_EV_BERASE,
		SFCP_EV_CERASE, SFCP_EV_BUSYEN, SFCP_EV_BUSYDIS, SFCP_EV_HOLDEN
	} sfcp_event_t;
endpackage : sfcp_pkg
`default_nettype wire

/* File: rtl/sfcp_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module sfcp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock_in,
	input  wire logic             rst_b_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : sfcp_sync
`default_nettype wire

/* File: rtl/sfcp_range.sv */
`timescale 1ns/100ps
`default_nettype none
// Registered protection check of one target address.
module sfcp_range
	import sfcp_pkg::*;
#(
	parameter int AW = 24
) (
	input  wire logic          clock_in,
	input  wire logic          rst_b_in,
	input  wire logic [1:0]    density_in,
	input  wire logic [2:0]    level_in,
	input  wire logic [AW-1:0] addr_in,
	output logic               protected_out
);
	function automatic logic is_prot(input logic [1:0] dens, input logic [2:0] lvl,
	                                 input logic [AW-1:0] a);
		logic [3:0] top;
		top = 4'h0;
		case (dens)
			DENS_512K: top = {2'h0, a[15:14]};
			DENS_1M:   top = {2'h0, a[16:15]};
			DENS_2M:   top = {2'h0, a[17:16]};
			default:   top = {1'h0, a[18:16]};
		endcase
		if (dens == DENS_4M) begin
			if (lvl[2]) return 1'b1;
			case (lvl[1:0])
				2'h1:    return top[2:0] == 3'h7;
				2'h2:    return top[2:1] == 2'h3;
				2'h3:    return top[2];
				default: return 1'b0;
			endcase
		end
		case (lvl[1:0])
			2'h1:    return top[1:0] == 2'h3;
			2'h2:    return top[1];
			2'h3:    return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : is_prot

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			protected_out <= 1'b1;
		end else begin
			protected_out <= is_prot(density_in, level_in, addr_in);
		end
	end
endmodule : sfcp_range
`default_nettype wire

/* File: verification/sfcp_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module sfcp_top_sva
	import sfcp_pkg::*;
#(
	parameter int AW = 24
) (
	// System.
	input wire logic        clock_in,
	input wire logic        rst_b_in,
	// Serial link.
	input wire logic        cs_b_in,
	input wire logic        wp_b_in,
	// Status and commands.
	input wire logic        write_latch_bit_out,
	input wire logic        protect_lock_bit_out,
	input wire logic [2:0]  protect_level_out,
	input wire logic        cmd_valid_out,
	input wire sfcp_event_t cmd_kind_out,
	input wire logic        refused_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);
	a_reset_prot_state: assert property ($rose(rst_b_in) |->
		protect_level_out == 3'h7 && !protect_lock_bit_out)
		else $error("protection state wrong after reset");
	a_accept_needs_latch: assert property (cmd_valid_out |->
		$past(write_latch_bit_out))
		else $error("write accepted without latch");
	a_latch_clears: assert property (cmd_valid_out || refused_out |->
		##[0:1] !write_latch_bit_out)
		else $error("latch kept after write");
	a_pulse_exclusive: assert property (!(cmd_valid_out && refused_out))
		else $error("accept and refuse together");
	a_full_erase_level: assert property (cmd_valid_out &&
		cmd_kind_out == SFCP_EV_CERASE |-> protect_level_out == 3'h0)
		else $error("full erase with level set");
	a_lock_frozen: assert property ((!wp_b_in && protect_lock_bit_out) [*6]
		|=> $stable(protect_level_out) && protect_lock_bit_out)
		else $error("locked protection changed");
	a_latch_after_deselect: assert property ($changed(write_latch_bit_out)
		|-> $past(cs_b_in, 3))
		else $error("latch moved inside frame");
	a_refuse_kind: assert property (refused_out |-> cmd_kind_out inside
		{SFCP_EV_BPROG, SFCP_EV_AAI, SFCP_EV_SERASE, SFCP_EV_BERASE, SFCP_EV_CERASE})
		else $error("refusal of non-write frame");
endmodule : sfcp_top_sva
bind sfcp_top sfcp_top_sva #(.AW(AW)) u_sva (
	.clock_in(clock_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b_in),
	.wp_b_in(wp_b_in), .write_latch_bit_out(write_latch_bit_out),
	.protect_lock_bit_out(protect_lock_bit_out),
	.protect_level_out(protect_level_out), .cmd_valid_out(cmd_valid_out),
	.cmd_kind_out(cmd_kind_out), .refused_out(refused_out));
`default_nettype wire

/* File: verification/sfcp_host.sv */
`timescale 1ns/100ps
`default_nettype none
// The link clock stands still between frames, as a real host does.
module sfcp_host (
	// Serial link.
	output logic sck_out,
	output logic cs_b_out,
	output logic si_out
);
	initial begin
		sck_out  = 1'b0;
		cs_b_out = 1'b1;
		si_out   = 1'b0;
	end
	// A nonzero cut drops final bits, leaving the last byte short.
	task automatic send(input logic [7:0] q [$], input int cut);
		int n;
		n = 8 * q.size() - cut;
		// The offset keeps link edges away from the system clock's edges.
		#37;
		cs_b_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			#40;
			si_out = q[i / 8][7 - i % 8];
			#40;
			sck_out = 1'b1;
			#80;
			sck_out = 1'b0;
		end
		#80;
		cs_b_out = 1'b1;
		si_out   = ~si_out;
		#200;
	endtask : send
endmodule : sfcp_host
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import sfcp_pkg::*;
;
	logic clock_in = 1'b0, rst_b_in = 1'b0, wp_b_in = 1'b1, busy = 1'b0;
	logic sck, cs_b, si, wlat, lock, busy_en, hold, auto_increment_program, vld, act, ref_p;
	logic [2:0] level;
	logic [1:0] density = DENS_4M;
	sfcp_event_t kind;
	logic [23:0] addr;
	logic [7:0] data;
	int miscompares = 0, comparisons = 0, nv = 0, nr = 0, v0, r0;
	always #5 clock_in = ~clock_in;
	sfcp_host u_host (.sck_out(sck), .cs_b_out(cs_b), .si_out(si));
	sfcp_top DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .sck_in(sck),
		.cs_b_in(cs_b), .si_in(si), .wp_b_in(wp_b_in), .density_in(density),
		.engine_busy_in(busy), .write_latch_bit_out(wlat),
		.protect_lock_bit_out(lock), .protect_level_out(level),
		.busy_out_enable_out(busy_en), .hold_function_out(hold),
		.aai_mode_out(auto_increment_program), .cmd_valid_out(vld), .cmd_kind_out(kind),
		.cmd_addr_out(addr), .cmd_data_out(data), .read_active_out(act),
		.refused_out(ref_p));
	// Pulses last one cycle, so they are counted as they pass.
	always @(posedge clock_in) begin
		if (vld === 1'b1) nv <= nv + 1;
		if (ref_p === 1'b1) nr <= nr + 1;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic xfer(input logic [7:0] q [$], input int cut);
		u_host.send(q, cut);
		repeat (12) @(posedge clock_in);
	endtask : xfer
	task automatic wsr(input logic [7:0] b);
		xfer({OP_WRITE_EN}, 0);
		xfer({OP_STAT_WRITE, b}, 0);
	endtask : wsr
	task automatic prog(input logic [23:0] a);
		xfer({OP_WRITE_EN}, 0);
		xfer({OP_BYTE_PROG, a[23:16], a[15:8], a[7:0], 8'h5a}, 0);
	endtask : prog
	task automatic t_reset;
		check(level, LEVEL_RESET);
		check(lock, LOCK_RESET);
		check(wlat, 1'b0);
		check(hold, 1'b0);
		check(busy_en, 1'b0);
	endtask : t_reset
	task automatic t_latch;
		xfer({OP_WRITE_EN}, 3);
		check(wlat, 1'b0);
		xfer({OP_WRITE_EN}, 0);
		check(wlat, 1'b1);
		xfer({OP_WRITE_DIS}, 0);
		check(wlat, 1'b0);
		r0 = nr;
		xfer({OP_BYTE_PROG, 8'h00, 8'h01, 8'h00, 8'h11}, 0);
		check(24'(nr - r0), 24'h1);
		xfer({OP_WRITE_EN}, 8);
		check(24'(nr - r0), 24'h1);
	endtask : t_latch
	task automatic t_protect;
		wsr(8'h04);
		check(level, 3'h1);
		check(wlat, 1'b0);
		v0 = nv;
		r0 = nr;
		prog(24'h070000);
		check(24'(nr - r0), 24'h1);
		prog(24'h06ffff);
		check(24'(nv - v0), 24'h1);
		check(kind, SFCP_EV_BPROG);
		check(addr, 24'h06ffff);
		check(data, 8'h5a);
		xfer({OP_WRITE_EN}, 0);
		xfer({OP_AAI_PROG, 8'h00, 8'h10, 8'h00, 8'h12, 8'h34}, 0);
		check(kind, SFCP_EV_AAI);
		check(data, 8'h34);
		check(auto_increment_program, 1'b1);
		@(posedge clock_in) busy <= 1'b1;
		prog(24'h000100);
		check(24'(nr - r0), 24'h2);
		@(posedge clock_in) busy <= 1'b0;
	endtask : t_protect
	task automatic t_erase;
		r0 = nr;
		xfer({OP_WRITE_EN}, 0);
		xfer({OP_CHIP_ERA_A}, 0);
		check(24'(nr - r0), 24'h1);
		wsr(8'h00);
		v0 = nv;
		xfer({OP_WRITE_EN}, 0);
		xfer({OP_CHIP_ERA_B}, 0);
		check(kind, SFCP_EV_CERASE);
		xfer({OP_WRITE_EN}, 0);
		xfer({OP_SECT_ERASE, 8'h01, 8'h20, 8'h00}, 0);
		check(kind, SFCP_EV_SERASE);
		check(addr, 24'h012000);
		xfer({OP_WRITE_EN}, 0);
		xfer({OP_BLK_ERASE, 8'h02, 8'h80, 8'h00}, 0);
		check(kind, SFCP_EV_BERASE);
		check(24'(nv - v0), 24'h3);
	endtask : t_erase
	task automatic t_lock;
		@(posedge clock_in) wp_b_in <= 1'b0;
		wsr(8'h88);
		check(lock, 1'b1);
		wsr(8'h00);
		check(lock, 1'b1);
		check(level, 3'h2);
		@(posedge clock_in) wp_b_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		wsr(8'h00);
		check(lock, 1'b0);
		check(level, 3'h0);
	endtask : t_lock
	task automatic t_cmds;
		xfer({OP_BUSY_EN}, 0);
		check(busy_en, 1'b1);
		xfer({OP_BUSY_DIS}, 0);
		check(busy_en, 1'b0);
		xfer({OP_HOLD_EN}, 0);
		check(hold, 1'b1);
		xfer({OP_STAT_WEN}, 0);
		xfer({OP_STAT_WRITE, 8'h0c}, 0);
		check(level, 3'h3);
	endtask : t_cmds
	task automatic t_read(input logic [7:0] op);
		v0 = nv;
		r0 = nr;
		fork
			u_host.send({op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
			begin
				repeat (650) @(posedge clock_in);
				check(act, 1'b1);
			end
		join
		repeat (12) @(posedge clock_in);
		check(act, 1'b0);
		check(24'(nv - v0 + nr - r0), 24'h0);
	endtask : t_read
	task automatic t_density(input logic [1:0] d, input logic [7:0] st,
	                         input logic [23:0] hit, input logic [23:0] miss);
		@(posedge clock_in) density <= d;
		wsr(st);
		v0 = nv;
		r0 = nr;
		prog(hit);
		check(24'(nr - r0), 24'h1);
		prog(miss);
		check(24'(nv - v0), 24'h1);
	endtask : t_density
	initial begin
		repeat (5) @(posedge clock_in);
		rst_b_in <= 1'b1;
		@(posedge clock_in);
		t_reset();
		t_latch();
		t_protect();
		t_erase();
		t_lock();
		t_cmds();
		t_read(OP_READ);
		t_read(OP_FAST_READ);
		t_read(OP_STAT_READ);
		t_read(OP_ID_READ_A);
		t_read(OP_STD_ID);
		t_density(DENS_512K, 8'h04, 24'h00c000, 24'h00bfff);
		t_density(DENS_1M, 8'h08, 24'h010000, 24'h00ffff);
		t_density(DENS_2M, 8'h04, 24'h030000, 24'h02ffff);
		@(posedge clock_in) rst_b_in <= 1'b0;
		repeat (5) @(posedge clock_in);
		rst_b_in <= 1'b1;
		@(posedge clock_in);
		t_reset();
		summarize();
	end
	// A hang costs one mismatch and ends the run through the same verdict.
	initial begin
		repeat (60000) @(posedge clock_in);
		miscompares++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire
